/* rtl/fap_pkg.sv */
// Constants for the flash protection host controller
package fap_pkg;
  localparam int FAP_AW = 25;
  localparam int FAP_DW = 16;
  localparam int FAP_CLK_NS = 20;
  // Software register byte offsets
  localparam logic [5:0] FAP_CTRL_OFS = 6'h00;
  localparam logic [5:0] FAP_ADDR_OFS = 6'h04;
  localparam logic [5:0] FAP_WDATA_OFS = 6'h08;
  localparam logic [5:0] FAP_RDATA_OFS = 6'h0c;
  localparam logic [5:0] FAP_STAT_OFS = 6'h10;
  localparam logic [5:0] FAP_PW0_OFS = 6'h14;
  localparam logic [5:0] FAP_PW1_OFS = 6'h18;
  localparam logic [5:0] FAP_PW2_OFS = 6'h1c;
  localparam logic [5:0] FAP_PW3_OFS = 6'h20;
  // Control fields
  localparam int FAP_OP_LSB = 0;
  localparam int FAP_PAGE_KEEP_BIT = 3;
  localparam logic [2:0] FAP_OP_READ = 3'h1;
  localparam logic [2:0] FAP_OP_WRITE = 3'h2;
  localparam logic [2:0] FAP_OP_UNLOCK = 3'h3;
  localparam logic [2:0] FAP_OP_RESET = 3'h4;
  // Status fields
  localparam int FAP_ST_BUSY = 0;
  localparam int FAP_ST_GAP = 1;
  localparam int FAP_ST_REFUSED = 2;
  localparam int FAP_ST_RESET_DONE = 3;
  localparam int FAP_ST_PAGE_HIT = 4;
  // Times in ns (spacing gap in us), least times round up to cycles
  localparam int FAP_T_ACC_NS = 110;
  localparam int FAP_T_PACC_NS = 25;
  localparam int FAP_T_WP_NS = 35;
  localparam int FAP_T_RP_NS = 200;
  localparam int FAP_T_RPH_NS = 35000;
  localparam int FAP_GAP_US = 120;
  localparam int FAP_ACC_CYC = (FAP_T_ACC_NS + FAP_CLK_NS - 1) / FAP_CLK_NS;
  localparam int FAP_PACC_CYC = (FAP_T_PACC_NS + FAP_CLK_NS - 1) / FAP_CLK_NS;
  localparam int FAP_WP_CYC = (FAP_T_WP_NS + FAP_CLK_NS - 1) / FAP_CLK_NS;
  localparam int FAP_RP_CYC = (FAP_T_RP_NS + FAP_CLK_NS - 1) / FAP_CLK_NS;
  localparam int FAP_RPH_CYC = (FAP_T_RPH_NS + FAP_CLK_NS - 1) / FAP_CLK_NS;
  localparam int FAP_GAP_CYC = (FAP_GAP_US * 1000 + FAP_CLK_NS - 1) / FAP_CLK_NS;
  localparam logic [1:0] FAP_PW_LAST = 2'h3;
  localparam logic [2:0] FAP_CTRL_RST = 3'h0;
  typedef enum logic [5:0] {
    FAP_S_IDLE = 6'b000001,
    FAP_S_SETUP = 6'b000010,
    FAP_S_STROBE = 6'b000100,
    FAP_S_HOLD = 6'b001000,
    FAP_S_RESET = 6'b010000,
    FAP_S_RECOVER = 6'b100000
  } fap_state_t;
endpackage : fap_pkg

/* rtl/fap_host_ctrl.sv */
// Host controller driving a parallel NOR flash with password protection
// Notes on behaviour
// - Host sends all four password words; exact match sets the lock.
// - Unlock attempts at most once per 100 us plus or minus 20 us.
// - Same upper address with chip select low gives a fast page read.
// - Hardware reset aborts program or erase; host reissues afterwards.
//
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module fap_host_ctrl
  import fap_pkg::*;
#(
  parameter int GAP_CYC = FAP_GAP_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [FAP_AW-1:0] fl_addr,
  input wire logic [FAP_DW-1:0] fl_dq_in,
  output logic [FAP_DW-1:0] fl_dq_out,
  output logic fl_dq_oe,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n,
  output logic fl_reset_n
);
  fap_state_t state_reg, state_next;
  logic [2:0] op_reg, op_next;
  logic keep_reg, keep_next;
  logic [FAP_AW-1:0] addr_reg, addr_next;
  logic [FAP_DW-1:0] wdata_reg, wdata_next;
  logic [FAP_DW-1:0] rdata_reg, rdata_next;
  logic [FAP_DW-1:0] pw_reg [4];
  logic [FAP_DW-1:0] pw_next [4];
  logic [1:0] pw_idx_reg, pw_idx_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] gap_reg, gap_next;
  logic refused_reg, refused_next;
  logic rst_done_reg, rst_done_next;
  logic hit_reg, hit_next;
  logic page_ok_reg, page_ok_next;
  logic [FAP_AW-5:0] page_reg, page_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic [FAP_AW-1:0] fa_reg, fa_next;
  logic [FAP_DW-1:0] dq_reg, dq_next;
  logic oe_en_reg, oe_en_next;
  logic ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
  logic rst_n_reg, rst_n_next;
  logic req, busy, wr_go;
  logic [31:0] status;

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign busy = (state_reg != FAP_S_IDLE);
  // Only the low halfword lane carries the 16-bit fields
  assign status = {27'h0, hit_reg, rst_done_reg, refused_reg,
                   (gap_reg != 16'h0), busy};
  assign wr_go = req & wb_we_i & (wb_adr_i == FAP_CTRL_OFS) & wb_sel_i[0];

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    keep_next = keep_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    pw_next = pw_reg;
    pw_idx_next = pw_idx_reg;
    cnt_next = cnt_reg;
    gap_next = (gap_reg != 16'h0) ? gap_reg - 16'h1 : gap_reg;
    refused_next = refused_reg;
    rst_done_next = rst_done_reg;
    hit_next = hit_reg;
    page_ok_next = page_ok_reg;
    page_next = page_reg;
    ack_next = req;
    dat_next = 32'h0;
    fa_next = fa_reg;
    dq_next = dq_reg;
    oe_en_next = oe_en_reg;
    ce_n_next = ce_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    rst_n_next = rst_n_reg;
    // Register bus side
    if (req && !wb_we_i) begin
      if (wb_adr_i == FAP_CTRL_OFS) begin
        dat_next = {28'h0, keep_reg, op_reg};
      end else if (wb_adr_i == FAP_ADDR_OFS) begin
        dat_next = {{(32-FAP_AW){1'b0}}, addr_reg};
      end else if (wb_adr_i == FAP_WDATA_OFS) begin
        dat_next = {16'h0, wdata_reg};
      end else if (wb_adr_i == FAP_RDATA_OFS) begin
        dat_next = {16'h0, rdata_reg};
      end else if (wb_adr_i == FAP_STAT_OFS) begin
        dat_next = status;
      end else begin
        dat_next = 32'h0;
      end
    end else if (req && wb_we_i) begin
      if (wb_adr_i == FAP_ADDR_OFS) begin
        if (!busy) addr_next = wb_dat_i[FAP_AW-1:0];
      end else if (wb_adr_i == FAP_WDATA_OFS) begin
        if (!busy) wdata_next = wb_dat_i[FAP_DW-1:0];
      end else if (wb_adr_i == FAP_STAT_OFS) begin
        if (wb_dat_i[FAP_ST_REFUSED]) refused_next = 1'b0;
        if (wb_dat_i[FAP_ST_RESET_DONE]) rst_done_next = 1'b0;
      end else if (wb_adr_i == FAP_PW0_OFS) begin
        if (!busy) pw_next[0] = wb_dat_i[FAP_DW-1:0];
      end else if (wb_adr_i == FAP_PW1_OFS) begin
        if (!busy) pw_next[1] = wb_dat_i[FAP_DW-1:0];
      end else if (wb_adr_i == FAP_PW2_OFS) begin
        if (!busy) pw_next[2] = wb_dat_i[FAP_DW-1:0];
      end else if (wb_adr_i == FAP_PW3_OFS) begin
        if (!busy) pw_next[3] = wb_dat_i[FAP_DW-1:0];
      end
    end
    // A start while an op runs is dropped and flagged
    if (wr_go && busy) refused_next = 1'b1;
    // Flash sequencer
    case (state_reg)
      FAP_S_IDLE: begin
        if (wr_go) begin
          op_next = wb_dat_i[FAP_OP_LSB +: 3];
          keep_next = wb_dat_i[FAP_PAGE_KEEP_BIT];
          pw_idx_next = 2'h0;
          if (wb_dat_i[FAP_OP_LSB +: 3] == FAP_OP_READ) begin
            // Page hit only if chip select never rose since
            hit_next = page_ok_reg && (page_reg == addr_reg[FAP_AW-1:4]);
            fa_next = addr_reg;
            oe_en_next = 1'b0;
            state_next = FAP_S_SETUP;
          end else if (wb_dat_i[FAP_OP_LSB +: 3] == FAP_OP_WRITE) begin
            hit_next = 1'b0;
            state_next = FAP_S_SETUP;
          end else if (wb_dat_i[FAP_OP_LSB +: 3] == FAP_OP_UNLOCK) begin
            hit_next = 1'b0;
            // Attempts inside the spacing window are refused
            if (gap_reg != 16'h0) begin
              refused_next = 1'b1;
              state_next = FAP_S_IDLE;
            end else begin
              state_next = FAP_S_SETUP;
            end
          end else if (wb_dat_i[FAP_OP_LSB +: 3] == FAP_OP_RESET) begin
            // Reset pulse aborts whatever the flash runs
            ce_n_next = 1'b1;
            oe_n_next = 1'b1;
            we_n_next = 1'b1;
            oe_en_next = 1'b0;
            page_ok_next = 1'b0;
            rst_n_next = 1'b0;
            cnt_next = 16'(FAP_RP_CYC);
            state_next = FAP_S_RESET;
          end else begin
            refused_next = 1'b1;
          end
        end else if (req && wb_we_i && wb_adr_i == FAP_CTRL_OFS) begin
          refused_next = 1'b1;
        end
      end
      FAP_S_SETUP: begin
        if (op_reg == FAP_OP_READ) begin
          if (hit_reg) begin
            // Page data only shows with both selects low
            oe_n_next = 1'b0;
            cnt_next = 16'(FAP_PACC_CYC);
            state_next = FAP_S_STROBE;
          end else if (!ce_n_reg) begin
            // Deselect for one cycle so the flash restarts the page
            ce_n_next = 1'b1;
            oe_n_next = 1'b1;
          end else begin
            ce_n_next = 1'b0;
            oe_n_next = 1'b0;
            cnt_next = 16'(FAP_ACC_CYC);
            state_next = FAP_S_STROBE;
          end
        end else begin
          ce_n_next = 1'b0;
          oe_n_next = 1'b1;
          oe_en_next = 1'b1;
          page_ok_next = 1'b0;
          if (op_reg == FAP_OP_UNLOCK) begin
            fa_next = {addr_reg[FAP_AW-1:2], pw_idx_reg};
            dq_next = pw_reg[pw_idx_reg]; // Words in order 0..3
          end else begin
            fa_next = addr_reg;
            dq_next = wdata_reg;
          end
          we_n_next = 1'b0;
          cnt_next = 16'(FAP_WP_CYC);
          state_next = FAP_S_STROBE;
        end
      end
      FAP_S_STROBE: begin
        if (cnt_reg > 16'h1) begin
          cnt_next = cnt_reg - 16'h1;
        end else if (op_reg == FAP_OP_READ) begin
          rdata_next = fl_dq_in;
          page_next = fa_reg[FAP_AW-1:4];
          // Holding both selects low keeps the page open
          oe_n_next = ~keep_reg;
          page_ok_next = keep_reg;
          ce_n_next = ~keep_reg;
          state_next = FAP_S_IDLE;
        end else begin
          we_n_next = 1'b1;
          state_next = FAP_S_HOLD;
        end
      end
      FAP_S_HOLD: begin
        ce_n_next = 1'b1;
        oe_en_next = 1'b0;
        if (op_reg == FAP_OP_UNLOCK && pw_idx_reg != FAP_PW_LAST) begin
          pw_idx_next = pw_idx_reg + 2'h1;
          state_next = FAP_S_SETUP;
        end else begin
          if (op_reg == FAP_OP_UNLOCK) begin
            gap_next = 16'(GAP_CYC); // Spacing before next attempt
          end
          state_next = FAP_S_IDLE;
        end
      end
      FAP_S_RESET: begin
        if (cnt_reg > 16'h1) begin
          cnt_next = cnt_reg - 16'h1;
        end else begin
          rst_n_next = 1'b1;
          cnt_next = 16'(FAP_RPH_CYC);
          state_next = FAP_S_RECOVER;
        end
      end
      FAP_S_RECOVER: begin
        if (cnt_reg > 16'h1) begin
          cnt_next = cnt_reg - 16'h1;
        end else begin
          // Software must reissue any aborted operation
          rst_done_next = 1'b1;
          state_next = FAP_S_IDLE;
        end
      end
      default: state_next = FAP_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= FAP_S_IDLE;
      op_reg <= FAP_CTRL_RST;
      keep_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      pw_reg <= '{default: '1};
      pw_idx_reg <= 2'h0;
      cnt_reg <= 16'h0;
      gap_reg <= 16'h0;
      refused_reg <= 1'b0;
      rst_done_reg <= 1'b0;
      hit_reg <= 1'b0;
      page_ok_reg <= 1'b0;
      page_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      fa_reg <= '0;
      dq_reg <= '0;
      oe_en_reg <= 1'b0;
      ce_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      rst_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      keep_reg <= keep_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      pw_reg <= pw_next;
      pw_idx_reg <= pw_idx_next;
      cnt_reg <= cnt_next;
      gap_reg <= gap_next;
      refused_reg <= refused_next;
      rst_done_reg <= rst_done_next;
      hit_reg <= hit_next;
      page_ok_reg <= page_ok_next;
      page_reg <= page_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      fa_reg <= fa_next;
      dq_reg <= dq_next;
      oe_en_reg <= oe_en_next;
      ce_n_reg <= ce_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      rst_n_reg <= rst_n_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign fl_addr = fa_reg;
  assign fl_dq_out = dq_reg;
  assign fl_dq_oe = oe_en_reg;
  assign fl_ce_n = ce_n_reg;
  assign fl_oe_n = oe_n_reg;
  assign fl_we_n = we_n_reg;
  assign fl_reset_n = rst_n_reg;

  a_pw_all_words: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == FAP_S_HOLD && op_reg == FAP_OP_UNLOCK &&
     pw_idx_reg != FAP_PW_LAST) |=> state_reg == FAP_S_SETUP)
    else $error("password sequence ended early");
  a_unlock_gap_ok: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(fl_dq_oe) && op_reg == FAP_OP_UNLOCK && pw_idx_reg == 2'h0
    |-> gap_reg == 16'h0)
    else $error("unlock issued inside spacing window");
  a_gap_loaded: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == FAP_S_HOLD && op_reg == FAP_OP_UNLOCK &&
     pw_idx_reg == FAP_PW_LAST) |=> gap_reg == 16'(GAP_CYC))
    else $error("spacing window not started");
  a_page_no_break: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == FAP_S_SETUP && op_reg == FAP_OP_READ && hit_reg)
    |-> !fl_ce_n ##1 !fl_ce_n)
    else $error("page hit dropped chip select");
  a_page_oe_low: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == FAP_S_SETUP && op_reg == FAP_OP_READ && hit_reg)
    |-> !fl_oe_n ##1 !fl_oe_n)
    else $error("page hit raised output enable");
  a_miss_deselect: assert property (@(posedge core_clk) disable iff (!nrst)
    (state_reg == FAP_S_SETUP && op_reg == FAP_OP_READ && !hit_reg &&
     !fl_ce_n) |=> fl_ce_n ##1 !fl_ce_n)
    else $error("random read without deselect");
  a_reset_width: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(fl_reset_n) |-> !fl_reset_n [*8] ##1 !fl_reset_n ##1 !fl_reset_n
    ##1 fl_reset_n)
    else $error("reset pulse width wrong");
  a_reset_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    !fl_reset_n |-> fl_ce_n && fl_we_n && !fl_dq_oe)
    else $error("flash accessed during reset");
  a_ack_single: assert property (@(posedge core_clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule : fap_host_ctrl
`default_nettype wire

/* testbench/fap_flash_model.sv */
// Behavioural password-mode flash device seen by the host controller
`timescale 1ns/1ns
`default_nettype none
module fap_flash_model
  import fap_pkg::*;
#(
  parameter int LOCK_NS = 2000
) (
  input wire logic [FAP_AW-1:0] fl_addr,
  output logic [FAP_DW-1:0] fl_dq_in,
  input wire logic [FAP_DW-1:0] fl_dq_out,
  input wire logic fl_dq_oe,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  input wire logic fl_reset_n
);
  localparam logic [22:0] PW_BASE = 23'h400000;
  localparam logic [FAP_AW-1:0] LOCK_ADR = 25'h1ffffff;
  logic [FAP_DW-1:0] mem [0:255];
  logic [FAP_DW-1:0] pw [0:3];
  logic [FAP_DW-1:0] hold_val;
  logic lock;
  logic pw_ok;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    for (int i = 0; i < 4; i++) pw[i] = 16'hffff;
    lock = 1'b0;
    pw_ok = 1'b0;
    hold_val = 16'h0000;
  end
  // Lock comes up cleared in password mode
  always @(negedge fl_reset_n) lock = 1'b0;
  always @(posedge fl_we_n) begin
    if (!fl_ce_n && fl_dq_oe && fl_reset_n) begin
      if (fl_addr[24:2] == PW_BASE) begin
        pw_ok = (fl_addr[1:0] == 2'h0 || pw_ok) &&
          fl_dq_out == pw[fl_addr[1:0]];
        // Mismatch leaves the lock cleared
        if (fl_addr[1:0] == 2'h3 && pw_ok) begin
          // Keeps running after the host deselects
          lock <= #(LOCK_NS) 1'b1;
        end
      end else begin
        mem[fl_addr[7:0]] = mem[fl_addr[7:0]] & fl_dq_out;
      end
    end
  end
  // Released bus shows the inverse, never a stale copy
  always @* begin
    if (!fl_ce_n && !fl_oe_n && fl_reset_n) begin
      hold_val = (fl_addr == LOCK_ADR) ? {15'h0, lock}
        : mem[fl_addr[7:0]];
      fl_dq_in = hold_val;
    end else begin
      fl_dq_in = ~hold_val;
    end
  end
endmodule // fap_flash_model
`default_nettype wire

/* testbench/fap_host_ctrl_bench.sv */
// Self-checking bench for the flash protection host controller
`timescale 1ns/1ns
`default_nettype none
module fap_host_ctrl_bench;
  import fap_pkg::*;
  localparam int GAP = 20;
  localparam logic [24:0] PW_ADR = 25'h1000000;
  localparam logic [24:0] LOCK_ADR = 25'h1ffffff;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [FAP_AW-1:0] fl_addr;
  logic [FAP_DW-1:0] fl_dq_in;
  logic [FAP_DW-1:0] fl_dq_out;
  logic fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  integer seed = 32'hc1d9;
  logic [31:0] rd, r;
  logic [15:0] exp_mem [0:255];
  logic [7:0] a;

  always #10 core_clk = ~core_clk;

  fap_host_ctrl #(.GAP_CYC(GAP)) dut_u (.core_clk(core_clk), .nrst(nrst),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fl_addr(fl_addr), .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n));

  fap_flash_model flash_u (.fl_addr(fl_addr), .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n));

  function automatic logic [15:0] prog_result(input logic [15:0] o,
      input logic [15:0] n);
    return o & n;
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic we, input logic [5:0] adr,
      input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= d;
    wb_sel <= 4'hf;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wait_idle;
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    while (rd[FAP_ST_BUSY] !== 1'b0) wb(1'b0, FAP_STAT_OFS, 32'h0);
  endtask

  task automatic fl_write(input logic [24:0] ad, input logic [15:0] d);
    wb(1'b1, FAP_ADDR_OFS, {7'h0, ad});
    wb(1'b1, FAP_WDATA_OFS, {16'h0, d});
    wb(1'b1, FAP_CTRL_OFS, {29'h0, FAP_OP_WRITE});
    wait_idle;
  endtask

  task automatic fl_read(input logic [24:0] ad, input logic keep);
    wb(1'b1, FAP_ADDR_OFS, {7'h0, ad});
    wb(1'b1, FAP_CTRL_OFS, {28'h0, keep, FAP_OP_READ});
    wait_idle;
    wb(1'b0, FAP_RDATA_OFS, 32'h0);
  endtask

  task automatic unlock_after_gap(input logic [15:0] w0);
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    while (rd[FAP_ST_GAP] !== 1'b0) wb(1'b0, FAP_STAT_OFS, 32'h0);
    wb(1'b1, FAP_ADDR_OFS, {7'h0, PW_ADR});
    wb(1'b1, FAP_PW0_OFS, {16'h0, w0});
    wb(1'b1, FAP_CTRL_OFS, {29'h0, FAP_OP_UNLOCK});
    wait_idle;
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Ceiling well above the longest path, reset op included
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      stop_test;
    end
  end

  initial begin
    for (int i = 0; i < 256; i++) exp_mem[i] = 16'hffff;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check("idle pins", 32'h6, {29'h0, fl_ce_n, fl_reset_n, fl_dq_oe});
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    check("status after reset", 32'h0, rd);
    wb(1'b0, 6'h3c, 32'h0);
    check("unmapped read", 32'h0, rd);
    // Few locations so reprogramming happens often
    for (int i = 0; i < 14; i++) begin
      r = $random(seed);
      a = {4'h0, r[3:0]};
      fl_write({17'h0, a}, r[31:16]);
      exp_mem[a] = prog_result(exp_mem[a], r[31:16]);
      fl_read({17'h0, a}, 1'b0);
      check("reprogrammed word", {16'h0, exp_mem[a]}, rd);
    end
    wb(1'b1, FAP_ADDR_OFS, 32'h0);
    wb(1'b1, FAP_WDATA_OFS, 32'h00ff);
    wb(1'b1, FAP_CTRL_OFS, {29'h0, FAP_OP_WRITE});
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    check("busy during write", 32'h1, {31'h0, rd[FAP_ST_BUSY]});
    wait_idle;
    exp_mem[0] = prog_result(exp_mem[0], 16'h00ff);
    fl_read(25'h0, 1'b0);
    check("word after write", {16'h0, exp_mem[0]}, rd);
    wb(1'b1, FAP_STAT_OFS, 32'h4);
    wb(1'b1, FAP_CTRL_OFS, 32'h7);
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    check("unknown op", 32'h1, {31'h0, rd[FAP_ST_REFUSED]});
    wb(1'b1, FAP_STAT_OFS, 32'h4);
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    check("refused cleared", 32'h0, {31'h0, rd[FAP_ST_REFUSED]});
    // Page hits while CE held low, then a raised CE
    // Last read moves page with CE low, forcing a deselect
    for (int i = 0; i < 5; i++) begin
      a = (i == 4) ? 8'h1c : 8'h0c + 8'(i);
      fl_read({17'h0, a}, (i == 2 || i == 4) ? 1'b0 : 1'b1);
      check("page data", {16'h0, exp_mem[a]}, rd);
      wb(1'b0, FAP_STAT_OFS, 32'h0);
      check("page hit", (i == 1 || i == 2) ? 32'h1 : 32'h0,
        {31'h0, rd[FAP_ST_PAGE_HIT]});
    end
    wb(1'b1, FAP_CTRL_OFS, {29'h0, FAP_OP_RESET});
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    check("reset pin low", 32'h0, {31'h0, fl_reset_n});
    check("busy during reset", 32'h1, {31'h0, rd[FAP_ST_BUSY]});
    // A start while the reset op runs must be dropped and flagged
    wb(1'b1, FAP_CTRL_OFS, {29'h0, FAP_OP_WRITE});
    wait_idle;
    check("reset done", 32'h1, {31'h0, rd[FAP_ST_RESET_DONE]});
    check("start while busy", 32'h1, {31'h0, rd[FAP_ST_REFUSED]});
    wb(1'b1, FAP_STAT_OFS, 32'hc);
    fl_read(LOCK_ADR, 1'b0);
    check("lock after reset", 32'h0, rd);
    unlock_after_gap(16'h1234);
    wb(1'b1, FAP_CTRL_OFS, {29'h0, FAP_OP_UNLOCK});
    wb(1'b0, FAP_STAT_OFS, 32'h0);
    check("unlock spacing", 32'h3, {30'h0, rd[FAP_ST_REFUSED],
      rd[FAP_ST_GAP]});
    wb(1'b1, FAP_STAT_OFS, 32'h4);
    repeat (150) @(posedge core_clk);
    fl_read(LOCK_ADR, 1'b0);
    check("lock after bad password", 32'h0, rd);
    unlock_after_gap(16'hffff);
    fl_read(LOCK_ADR, 1'b0);
    check("lock before delay", 32'h0, rd);
    repeat (150) @(posedge core_clk);
    fl_read(LOCK_ADR, 1'b0);
    check("lock after good password", 32'h1, rd);
    stop_test;
  end
endmodule // fap_host_ctrl_bench
`default_nettype wire
